// >>> sest_map.vh
// register offsets, field positions and reset values for the status bank
// assumes inclusion by bare name from the design file
`ifndef SEST_MAP_VH
`define SEST_MAP_VH
`define SEST_STATUS_ADDR     12'hAC8
`define SEST_CTL_ADDR        12'hACC
`define SEST_ADDR_LSB        1
`define SEST_ADDR_MSB        7
`define SEST_BLANK_BIT       22
`define SEST_ROLL_BIT        23
`define SEST_DONE_BIT        24
`define SEST_NACK_BIT        25
`define SEST_SSERR_BIT       27
`define SEST_CSUM_BIT        28
`define SEST_UNMAP_BIT       29
`define SEST_CSIGN_BIT       17
`define SEST_STATUS_RESET    32'h00000000
`define SEST_CTL_RESET       32'h00000000
`define SEST_DONE_BYTE       8'hC0
`endif

// >>> sest_status.v
// status register bank for the serial management ports, on AHB-Lite
// assumes event inputs are one-cycle pulses on hclk; the address strap
// is held steady around reset release
// assumes reset is held low for at least two hclk edges, so that the
// strap has crossed its two synchroniser stages before it is captured
// assumes zero wait states suffice: every access completes in one data
// phase and the response is always okay
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "sest_map.vh"

// Notes on behaviour
// - read-only slave address at bits 7:1
// - blank eeprom sets bit 22, w1c
// - bad word count or done byte sets blank
// - address rollover sets bit 23, w1c
// - init done or error stop sets bit 24
// - unexpected nack sets bit 25, w1c
// - misplaced start/stop sets bit 27, w1c
// - bad checksum or missing done sets 28
// - unmapped register target sets bit 29, w1c
// - checksum ignore bit 17 suppresses checksum error
module sest_status (
   // bus clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // hardware strap and init events
   input  wire [6:0]  slave_addr_strap,
   input  wire        init_blank,
   input  wire        init_word_count_bad,
   input  wire [7:0]  init_done_byte,
   input  wire        init_done_byte_vld,
   input  wire        init_rollover,
   input  wire        init_checksum_bad,
   input  wire        init_no_done_cmd,
   input  wire        init_unmapped,
   input  wire        init_finish,
   input  wire        init_error_stop,
   // master port events
   input  wire        nack_seen,
   input  wire        start_stop_misplaced,
   // control outputs
   output reg         checksum_ignore_bit
);

   // address strap: two synchroniser stages, then a one-time capture
   reg  [6:0]  strap_meta_reg;           // first synchroniser stage
   reg  [6:0]  strap_sync_reg;           // second synchroniser stage
   reg  [6:0]  slave_port_address_reg;   // captured strap
   reg         strap_taken_reg;          // strap latched once
   // eeprom initialisation flags
   reg         blank_reg;                // blank device, w1c
   reg         roll_reg;                 // address rollover, w1c
   reg         done_reg;                 // init finished, read-only
   // master port error flags
   reg         nack_error_flag_reg;      // unexpected nack, w1c
   reg         start_stop_error_flag_reg;     // misplaced start/stop, w1c
   reg         init_checksum_error_flag_reg;  // checksum or no done, w1c
   reg         unmapped_init_write_flag_reg;  // unmapped target, w1c
   // bus data phase tracking
   reg         wr_pend_reg;              // write data phase pending
   reg  [11:0] wr_addr_reg;              // latched write address
   // combinational decode
   wire        addr_ok;                  // valid address phase
   wire        wr_stat;                  // write data phase to status
   wire [31:0] status_word;              // assembled status read value
   wire        rd_take;                  // read address phase

   // next value for a w1c flag: set wins over clear
   // shared by all six write-one-to-clear flags
   function w1c_next;
      input cur;
      input set;
      input clr;
      begin
         w1c_next = set | (cur & ~clr);
      end
   endfunction

   // address phase decode
   // only nonseq and seq transfers count; idle and busy are ignored
   assign addr_ok = hsel & hready & htrans[1];
   assign rd_take = addr_ok & ~hwrite;
   // write strobe for clears
   // clears act in the data phase, while hwdata stands
   assign wr_stat = wr_pend_reg & (wr_addr_reg == `SEST_STATUS_ADDR);

   // reserved bits read as zero
   // bit layout: 29 unmapped, 28 checksum, 27 start/stop, 25 nack,
   // 24 done, 23 rollover, 22 blank, 7:1 slave address
   assign status_word = {2'b00, unmapped_init_write_flag_reg,
                         init_checksum_error_flag_reg,
                         start_stop_error_flag_reg, 1'b0,
                         nack_error_flag_reg, done_reg, roll_reg,
                         blank_reg, 14'h0000, slave_port_address_reg,
                         1'b0};

   // bus phase tracking and read data, zero wait states
   // read data are registered in the address phase, so they stand for
   // the whole data phase and until the next read address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // idle bus, ready high, okay response
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h000;
         hrdata      <= 32'h00000000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else begin
         // a write address phase arms the next data phase
         wr_pend_reg <= addr_ok & hwrite;
         wr_addr_reg <= {haddr[11:2], 2'b00};
         // read address phase: register the word now
         if (rd_take) begin
            // unmapped reads return zero
            if ({haddr[11:2], 2'b00} == `SEST_STATUS_ADDR) begin
               hrdata <= status_word;
            end else if ({haddr[11:2], 2'b00} == `SEST_CTL_ADDR) begin
               // control word: only the ignore bit is held
               hrdata <= {14'h0000, checksum_ignore_bit, 17'h00000};
            end else begin
               hrdata <= 32'h00000000;
            end
         end
      end
   end

   // strap synchroniser: the strap is a pin, so it passes two stages
   // before anything reads it; these stages run through reset so that
   // the settled value is ready at the first edge after release
   always @(posedge hclk) begin
      strap_meta_reg <= slave_addr_strap;
      strap_sync_reg <= strap_meta_reg;
   end

   // strap captured after reset release
   // the field is fixed once captured; a later strap change is ignored
   // until the next reset
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // cleared until the first edge after release
         slave_port_address_reg <= 7'h00;
         strap_taken_reg        <= 1'b0;
      end else if (!strap_taken_reg) begin
         // take the synchronised strap exactly once
         slave_port_address_reg <= strap_sync_reg;
         strap_taken_reg        <= 1'b1;
      end
   end

   // control bit for checksum ignore
   // only bit 17 of the control word is held; other bits read zero
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         checksum_ignore_bit <= 1'b0;
      end else if (wr_pend_reg && wr_addr_reg == `SEST_CTL_ADDR) begin
         // data phase of a control write
         checksum_ignore_bit <= hwdata[`SEST_CSIGN_BIT];
      end
   end

   // sticky flags
   // each w1c flag takes its event as set and a one in the matching
   // data bit of a status write as clear; a same-cycle set wins so an
   // event is never lost to a clear issued for an older one
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blank_reg                    <= 1'b0;
         roll_reg                     <= 1'b0;
         done_reg                     <= 1'b0;
         nack_error_flag_reg          <= 1'b0;
         start_stop_error_flag_reg    <= 1'b0;
         init_checksum_error_flag_reg <= 1'b0;
         unmapped_init_write_flag_reg <= 1'b0;
      end else begin
         // every flag is updated on every edge
         // blank flag
         // defect also sets blank
         // a done byte other than the expected value also counts
         blank_reg <= w1c_next(blank_reg, init_blank | init_word_count_bad
                       | (init_done_byte_vld
                          & (init_done_byte != `SEST_DONE_BYTE)),
                       wr_stat & hwdata[`SEST_BLANK_BIT]);
         roll_reg <= w1c_next(roll_reg, init_rollover,
                       wr_stat & hwdata[`SEST_ROLL_BIT]);
         // done is read-only, set only
         // writes never reach done; only reset clears it
         done_reg <= done_reg | init_finish | init_error_stop;
         nack_error_flag_reg <= w1c_next(nack_error_flag_reg, nack_seen,
                       wr_stat & hwdata[`SEST_NACK_BIT]);
         start_stop_error_flag_reg <= w1c_next(start_stop_error_flag_reg,
                       start_stop_misplaced,
                       wr_stat & hwdata[`SEST_SSERR_BIT]);
         // ignore bit masks checksum failure
         // a missing done command is never masked
         init_checksum_error_flag_reg <= w1c_next(
                       init_checksum_error_flag_reg,
                       (init_checksum_bad & ~checksum_ignore_bit)
                       | init_no_done_cmd,
                       wr_stat & hwdata[`SEST_CSUM_BIT]);
         unmapped_init_write_flag_reg <= w1c_next(
                       unmapped_init_write_flag_reg, init_unmapped,
                       wr_stat & hwdata[`SEST_UNMAP_BIT]);
      end
   end

endmodule // sest_status
`default_nettype wire

// >>> sest_far.sv
// far side: eeprom loader and bus master event pulses
// assumes hclk from the bench
`timescale 1ns/10ps
`default_nettype none
module sest_far (
   input  wire logic        hclk,
   output var  logic [10:0] ev
);
   initial ev = '0;
   // one-cycle pulse on event i
   task automatic pulse(input int i);
      @(posedge hclk) ev[i] <= 1'b1;
      @(posedge hclk) ev <= '0;
   endtask
endmodule // sest_far
`default_nettype wire

// >>> sest_props.sv
// checker: flags, address field and control bit of the bank
// assumes bind onto sest_status, one hclk domain
`timescale 1ns/10ps
`default_nettype none
module sest_props (
   input wire logic        hclk, hresetn, hsel, hwrite, hready,
   input wire logic [11:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic [31:0] hwdata, hrdata,
   input wire logic [6:0]  slave_addr_strap,
   input wire logic        init_blank, init_rollover, nack_seen,
   input wire logic        start_stop_misplaced, init_unmapped,
   input wire logic        checksum_ignore_bit
);
   logic rd_q, wc_q; // status read, control write
   wire  ap = hsel && hready && htrans[1];
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // data phase markers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q <= 1'b0;
         wc_q <= 1'b0;
      end else begin
         rd_q <= ap && !hwrite && haddr[11:2] == 10'h2B2;
         wc_q <= ap && hwrite && haddr[11:2] == 10'h2B3;
      end
   end
   a_addr_field: assert property (rd_q |->
      hrdata[7:1] == slave_addr_strap) else $error("addr field");
   a_resv_zero: assert property (rd_q |->
      {hrdata[31:30], hrdata[26], hrdata[21:8], hrdata[0]} == 0)
      else $error("reserved set");
   a_blank_set: assert property (init_blank ##2 rd_q |-> hrdata[22])
      else $error("blank lost");
   a_roll_set: assert property (rd_q && $past(init_rollover, 2) |->
      hrdata[23]) else $error("rollover lost");
   a_nack_set: assert property (nack_seen ##2 rd_q |-> hrdata[25])
      else $error("nack lost");
   a_ss_set: assert property ($past(start_stop_misplaced, 2)
      && rd_q |-> hrdata[27]) else $error("start stop lost");
   a_unmap_set: assert property (init_unmapped ##2 rd_q |-> hrdata[29])
      else $error("unmapped lost");
   a_ign_write: assert property (wc_q |=>
      checksum_ignore_bit == $past(hwdata[17])) else $error("ignore bit");
endmodule // sest_props
bind sest_status sest_props u_props (.hclk, .hresetn, .hsel, .hwrite,
   .hready, .haddr, .htrans, .hwdata, .hrdata, .slave_addr_strap,
   .init_blank, .init_rollover, .nack_seen, .start_stop_misplaced,
   .init_unmapped, .checksum_ignore_bit);
`default_nettype wire

// >>> smbus_eeprom_status_reg_bench.sv
// bench: bus accesses of the status bank around event pulses
// assumes sest_status, sest_far and the bound checker
`timescale 1ns/10ps
`default_nettype none
`include "sest_map.vh"
module smbus_eeprom_status_reg_bench;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ign;
   logic [11:0] haddr;
   logic [10:0] ev;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata;
   logic [6:0]  strap = 7'h5A;
   logic [7:0]  dbyte = 8'hC0;
   int          fails, compares;
   int          bt[9] = '{22, 22, 22, 23, 28, 28, 29, 25, 27};
   localparam logic [11:0] S = `SEST_STATUS_ADDR, C = `SEST_CTL_ADDR;
   wire  logic [31:0] A = {24'h000000, strap, 1'h0}; // strap at bits 7:1
   sest_far u_far (.hclk(hclk), .ev(ev));
   sest_status u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .slave_addr_strap(strap), .init_blank(ev[0]),
      .init_word_count_bad(ev[1]), .init_done_byte(dbyte),
      .init_done_byte_vld(ev[2]), .init_rollover(ev[3]),
      .init_checksum_bad(ev[4]), .init_no_done_cmd(ev[5]),
      .init_unmapped(ev[6]), .nack_seen(ev[7]),
      .start_stop_misplaced(ev[8]), .init_finish(ev[9]),
      .init_error_stop(ev[10]), .checksum_ignore_bit(ign));
   task automatic chk(input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic wt;
      @(posedge hclk);
      for (int n = 0; hreadyout !== 1'b1; n++) begin
         if (n == 50) chk(0, 1);
         if (n == 50) end_of_test;
         @(posedge hclk);
      end
   endtask
   // one transfer; on a read d is the expected word
   task automatic acc(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      hsize <= 3'h2;
      wt;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
      chk({31'h0, hresp}, 0);
      if (!w) chk(hrdata, d);
   endtask
   task automatic rst;
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask
   task automatic end_of_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   initial begin
      {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
      rst;
      acc(0, S, A);
      u_far.pulse(2);
      acc(0, S, A);
      dbyte <= 8'h3C;
      $display("reset test ends");
      for (int i = 0; i < 9; i++) begin
         u_far.pulse(i);
         acc(0, S, A | 1 << bt[i]);
         acc(1, S, 0);
         acc(0, S, A | 1 << bt[i]);
         acc(1, S, '1);
         acc(0, S, A);
      end
      $display("flag test ends");
      u_far.pulse(10);
      acc(1, S, '1);
      acc(0, S, A | 32'h01000000);
      strap <= 7'h2D;
      rst;
      acc(0, S, A);
      u_far.pulse(9);
      acc(0, S, A | 32'h01000000);
      acc(1, C, 32'h00020000);
      acc(0, C, 32'h00020000);
      chk({31'h0, ign}, 1);
      u_far.pulse(4);
      acc(0, S, A | 32'h01000000);
      u_far.pulse(5);
      acc(0, S, A | 32'h11000000);
      acc(0, 12'hAD0, 0);
      $display("done and ignore test ends");
      end_of_test;
   end
endmodule // smbus_eeprom_status_reg_bench
`default_nettype wire
